// *** include/xor_acc_pkg.sv ***
// constants shared by the xor accumulator datapath and its decoder
// assumes a 14-bit instruction word and an 8-bit data path
package xor_acc_pkg;
	// ***********************************************************
	// instruction word layout
	// ***********************************************************
	localparam int unsigned INSTR_W      = 14;
	localparam int unsigned OPC_MSB      = 13;
	localparam int unsigned OPC_LSB      = 8;
	localparam int unsigned OPC_W        = 6;
	localparam int unsigned DEST_BIT     = 7;
	localparam int unsigned ADDR_MSB     = 6;
	localparam int unsigned ADDR_LSB     = 0;
	localparam int unsigned FILE_ADDR_W  = 7;
	localparam logic [5:0]  XOR_OPCODE   = 6'h06;

	// ***********************************************************
	// data path and reset values
	// ***********************************************************
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned FILE_DEPTH   = 128;
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic [7:0]  FILE_RST     = 8'h00;
	localparam logic        ZERO_RST     = 1'b0;
	localparam logic        DEST_ACC     = 1'b0;
	localparam logic        DEST_FILE    = 1'b1;
endpackage : xor_acc_pkg

// *** rtl/xor_opcode_decode.sv ***
// splits an instruction word into opcode match, destination and address
// assumes the word is stable for the cycle in which it is presented
`timescale 1ns/1ps
module xor_opcode_decode #(
	parameter int unsigned AW = xor_acc_pkg::FILE_ADDR_W
) (
	// instruction word
	input  wire logic [xor_acc_pkg::INSTR_W-1:0] word_in,
	// decoded fields
	output logic                                 match_out,
	output logic                                 dest_out,
	output logic [AW-1:0]                        addr_out
);
	assign match_out = (word_in[xor_acc_pkg::OPC_MSB:xor_acc_pkg::OPC_LSB]
		== xor_acc_pkg::XOR_OPCODE);
	assign dest_out  = word_in[xor_acc_pkg::DEST_BIT];
	assign addr_out  = word_in[AW-1:0];
endmodule : xor_opcode_decode

// *** rtl/xor_accumulator_with_file.sv ***
// accumulator, 128-entry file and zero flag with the xor-with-file step
// assumes the decoder presents one instruction word per core cycle
// Function
// - decode opcode 000110, dest bit, 7-bit address
// - result is accumulator xor addressed file register
// - dest 0 writes accumulator, file unchanged
// - dest 1 writes file register, accumulator unchanged
`timescale 1ns/1ps
module xor_accumulator_with_file #(
	parameter int unsigned DW    = xor_acc_pkg::DATA_W,
	parameter int unsigned DEPTH = xor_acc_pkg::FILE_DEPTH,
	parameter int unsigned AW    = xor_acc_pkg::FILE_ADDR_W
) (
	// clock and reset
	input  wire logic                                clk_in,
	input  wire logic                                rst_n_in,
	// instruction from the decoder
	input  wire logic                                instr_valid_in,
	input  wire logic [xor_acc_pkg::INSTR_W-1:0]     instr_word_in,
	// loads from other instructions
	input  wire logic                                acc_load_in,
	input  wire logic [DW-1:0]                       acc_load_data_in,
	input  wire logic                                file_wr_in,
	input  wire logic [AW-1:0]                       file_wr_addr_in,
	input  wire logic [DW-1:0]                       file_wr_data_in,
	// file read-back
	input  wire logic [AW-1:0]                       file_rd_addr_in,
	output logic      [DW-1:0]                       file_rd_data_out,
	// state
	output logic      [DW-1:0]                       acc_out,
	output logic                                     zero_flag_out,
	output logic                                     exec_out
);
	// ***********************************************************
	// decode
	// ***********************************************************
	logic          match;
	logic          dest;
	logic [AW-1:0] addr;
	logic          exec;
	logic [DW-1:0] result;

	logic [DW-1:0] acc_ff;
	logic          zero_ff;
	logic [DW-1:0] rd_data_ff;
	logic [DW-1:0] file_mem [DEPTH];

	// the field split sits in its own module so that other instruction
	// steps of the core can reuse it without copying the layout
	xor_opcode_decode #(
		.AW        (AW)
	) u_decode (
		.word_in   (instr_word_in),
		.match_out (match),
		.dest_out  (dest),
		.addr_out  (addr)
	);

	assign exec   = instr_valid_in && match;
	assign result = acc_ff ^ file_mem[addr];

	// ***********************************************************
	// accumulator
	// ***********************************************************
	// the xor step wins over a plain load in the same cycle, because the
	// core never issues both at once and the instruction is the one in flight
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			acc_ff <= xor_acc_pkg::ACC_RST;
		end else if (exec) begin
			if (dest == xor_acc_pkg::DEST_ACC) begin
				acc_ff <= result;
			end
		end else if (acc_load_in) begin
			acc_ff <= acc_load_data_in;
		end
	end

	// ***********************************************************
	// file registers
	// ***********************************************************
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			// clearing the whole file costs a wide reset fan-out; it keeps
			// every register at a known value for the first instruction
			for (int i = 0; i < int'(DEPTH); i++) begin
				file_mem[i] <= xor_acc_pkg::FILE_RST;
			end
		end else if (exec) begin
			if (dest == xor_acc_pkg::DEST_FILE) begin
				file_mem[addr] <= result;
			end
		end else if (file_wr_in) begin
			file_mem[file_wr_addr_in] <= file_wr_data_in;
		end
	end

	// read-back shows the value before any write of the same edge
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_data_ff <= xor_acc_pkg::FILE_RST;
		end else begin
			rd_data_ff <= file_mem[file_rd_addr_in];
		end
	end

	// ***********************************************************
	// zero flag
	// ***********************************************************
	// loads from other instructions leave the flag alone; only the xor
	// step reports on its own result
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			zero_ff <= xor_acc_pkg::ZERO_RST;
		end else if (exec) begin
			zero_ff <= (result == '0);
		end
	end

	// ***********************************************************
	// outputs
	// ***********************************************************
	// exec_out is left combinational so the core sees the hit in-cycle
	assign acc_out          = acc_ff;
	assign zero_flag_out    = zero_ff;
	assign file_rd_data_out = rd_data_ff;
	assign exec_out         = exec;

	// ***********************************************************
	// checks
	// ***********************************************************
	// opcode field seen by the checks straight from the word, so a fault
	// in the decoder module does not hide behind its own output
	logic [xor_acc_pkg::OPC_W-1:0] chk_opcode;
	assign chk_opcode =
		instr_word_in[xor_acc_pkg::OPC_MSB:xor_acc_pkg::OPC_LSB];

	property p_decode;
		@(posedge clk_in) disable iff (!rst_n_in)
		exec == (instr_valid_in &&
			chk_opcode == xor_acc_pkg::XOR_OPCODE);
	endproperty
	a_decode: assert property (p_decode)
		else $error("opcode decode mismatch");

	// a_result and a_acc_value rebuild the xor from the old operands; a_to_acc and a_to_file compare against result
	property p_result;
		@(posedge clk_in) disable iff (!rst_n_in)
		(exec && dest == xor_acc_pkg::DEST_FILE) |=>
			(file_mem[$past(addr)] ==
			($past(acc_ff) ^ $past(file_mem[addr])));
	endproperty
	a_result: assert property (p_result)
		else $error("xor result wrong in file register");

	property p_acc_value;
		@(posedge clk_in) disable iff (!rst_n_in)
		(exec && dest == xor_acc_pkg::DEST_ACC) |=>
			(acc_ff == ($past(acc_ff) ^ $past(file_mem[addr])));
	endproperty
	a_acc_value: assert property (p_acc_value)
		else $error("xor result wrong in accumulator");

	property p_to_acc;
		@(posedge clk_in) disable iff (!rst_n_in)
		(exec && !dest) |=> (acc_ff == $past(result)) &&
			(file_mem[$past(addr)] == $past(file_mem[addr]));
	endproperty
	a_to_acc: assert property (p_to_acc)
		else $error("dest 0 did not land in accumulator only");

	property p_to_file;
		@(posedge clk_in) disable iff (!rst_n_in)
		(exec && dest) |=> (file_mem[$past(addr)] == $past(result)) &&
			$stable(acc_ff);
	endproperty
	a_to_file: assert property (p_to_file)
		else $error("dest 1 did not land in file only");

	property p_zero;
		@(posedge clk_in) disable iff (!rst_n_in)
		exec |=> (zero_ff == ($past(acc_ff) == $past(file_mem[addr])));
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag wrong after xor");

	property p_zero_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		!exec ##1 rst_n_in |-> $stable(zero_ff);
	endproperty
	a_zero_hold: assert property (p_zero_hold)
		else $error("zero flag moved without xor");

	property p_zero_load;
		@(posedge clk_in) disable iff (!rst_n_in)
		(!exec && (acc_load_in || file_wr_in)) |=> $stable(zero_ff);
	endproperty
	a_zero_load: assert property (p_zero_load)
		else $error("zero flag moved on a plain load");

	property p_refuse;
		@(posedge clk_in) disable iff (!rst_n_in)
		(instr_valid_in && chk_opcode != xor_acc_pkg::XOR_OPCODE) |->
			!exec;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("foreign opcode executed");

	property p_idle;
		@(posedge clk_in) disable iff (!rst_n_in)
		!instr_valid_in |-> !exec;
	endproperty
	a_idle: assert property (p_idle)
		else $error("executed without a valid word");

	// a side write in a cycle that executes with dest 0 must be dropped, not merged
	property p_side_file;
		@(posedge clk_in) disable iff (!rst_n_in)
		(exec && dest == xor_acc_pkg::DEST_ACC && file_wr_in) |=>
			(file_mem[$past(file_wr_addr_in)] ==
			$past(file_mem[file_wr_addr_in]));
	endproperty
	a_side_file: assert property (p_side_file)
		else $error("side write landed during xor");
endmodule : xor_accumulator_with_file

// *** verification/xor_accumulator_with_file_bench.sv ***
// self-checking bench for the xor accumulator datapath
// assumes the package is compiled first; the bench drives every port
`timescale 1ns/1ps
`define CHK(nm, e, s) begin \
	n_tests++; \
	if ((s) !== (e)) begin \
		n_errors++; \
		$display("mismatch %s exp %h got %h", nm, e, s); \
	end \
end
module xor_accumulator_with_file_bench;
	// ***********************************************************
	// stimulus and observed signals
	// ***********************************************************
	logic        clk_in = 1'b0;
	logic        rst_n_in, instr_valid_in, acc_load_in, file_wr_in;
	logic [13:0] instr_word_in;
	logic [7:0]  acc_load_data_in, file_wr_data_in, file_rd_data_out;
	logic [6:0]  file_wr_addr_in, file_rd_addr_in;
	logic [7:0]  acc_out, v;
	logic        zero_flag_out, exec_out;
	int          n_errors = 0;
	int          n_tests = 0;

	xor_accumulator_with_file dut (
		.clk_in           (clk_in),
		.rst_n_in         (rst_n_in),
		.instr_valid_in   (instr_valid_in),
		.instr_word_in    (instr_word_in),
		.acc_load_in      (acc_load_in),
		.acc_load_data_in (acc_load_data_in),
		.file_wr_in       (file_wr_in),
		.file_wr_addr_in  (file_wr_addr_in),
		.file_wr_data_in  (file_wr_data_in),
		.file_rd_addr_in  (file_rd_addr_in),
		.file_rd_data_out (file_rd_data_out),
		.acc_out          (acc_out),
		.zero_flag_out    (zero_flag_out),
		.exec_out         (exec_out)
	);

	always #5 clk_in = ~clk_in;

	// ***********************************************************
	// helpers
	// ***********************************************************
	task automatic step();
		@(posedge clk_in);
		#1;
	endtask : step

	// one xor-with-file instruction, executed in a single cycle
	task automatic run(input logic d, input logic [6:0] a);
		instr_valid_in = 1'b1;
		instr_word_in = {xor_acc_pkg::XOR_OPCODE, d, a};
		#1;
		`CHK("exec", 1'b1, exec_out)
		step();
		instr_valid_in = 1'b0;
	endtask : run

	// read-back is registered, so the value lands one edge later
	task automatic rd(input logic [6:0] a);
		file_rd_addr_in = a;
		step();
		v = file_rd_data_out;
	endtask : rd

	task automatic ld(input logic [7:0] w, input logic [6:0] a,
		input logic [7:0] d);
		{acc_load_in, acc_load_data_in} = {1'b1, w};
		{file_wr_in, file_wr_addr_in, file_wr_data_in} = {1'b1, a, d};
		step();
		{acc_load_in, file_wr_in} = 2'b00;
	endtask : ld

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// ***********************************************************
	// scenarios
	// ***********************************************************
	task automatic t_dest_acc();
		ld(8'hb5, 7'h05, 8'haf);
		run(1'b0, 7'h05);
		`CHK("acc", 8'h1a, acc_out)
		`CHK("zero", 1'b0, zero_flag_out)
		rd(7'h05);
		`CHK("file5", 8'haf, v)
		$display("dest accumulator done");
	endtask : t_dest_acc

	task automatic t_dest_file();
		run(1'b1, 7'h05);
		`CHK("acc", 8'h1a, acc_out)
		rd(7'h05);
		`CHK("file5", 8'hb5, v)
		ld(8'h3c, 7'h7f, 8'h3c);
		run(1'b1, 7'h7f);
		`CHK("zero", 1'b1, zero_flag_out)
		rd(7'h7f);
		`CHK("file127", 8'h00, v)
		$display("dest file done");
	endtask : t_dest_file

	task automatic t_refuse();
		instr_valid_in = 1'b1;
		instr_word_in = {6'h07, 1'b0, 7'h05};
		#1;
		`CHK("exec", 1'b0, exec_out)
		step();
		instr_valid_in = 1'b0;
		`CHK("acc", 8'h3c, acc_out)
		`CHK("zero", 1'b1, zero_flag_out)
		// side load and side write in the same cycle lose to the xor
		{acc_load_in, acc_load_data_in} = {1'b1, 8'hff};
		{file_wr_in, file_wr_addr_in} = {1'b1, 7'h05};
		file_wr_data_in = 8'h00;
		run(1'b0, 7'h05);
		{acc_load_in, file_wr_in} = 2'b00;
		`CHK("acc", 8'h89, acc_out)
		`CHK("zero", 1'b0, zero_flag_out)
		rd(7'h05);
		`CHK("file5", 8'hb5, v)
		$display("refusal done");
	endtask : t_refuse

	// reset in mid-run must clear accumulator, flag and file
	task automatic t_reset();
		ld(8'h5a, 7'h10, 8'h5a);
		run(1'b1, 7'h10);
		`CHK("zero", 1'b1, zero_flag_out)
		rst_n_in = 1'b0;
		repeat (2) step();
		rst_n_in = 1'b1;
		`CHK("acc", xor_acc_pkg::ACC_RST, acc_out)
		`CHK("zero", xor_acc_pkg::ZERO_RST, zero_flag_out)
		rd(7'h05);
		`CHK("file5", xor_acc_pkg::FILE_RST, v)
		$display("reset done");
	endtask : t_reset

	initial begin
		{rst_n_in, instr_valid_in, acc_load_in, file_wr_in} = 4'h0;
		{instr_word_in, acc_load_data_in, file_wr_data_in} = '0;
		{file_wr_addr_in, file_rd_addr_in} = '0;
		repeat (20) step();
		rst_n_in = 1'b1;
		t_dest_acc();
		t_dest_file();
		t_refuse();
		t_reset();
		conclude();
	end

	// cuts a hang short
	initial begin
		repeat (1000) @(posedge clk_in);
		n_errors++;
		conclude();
	end
endmodule : xor_accumulator_with_file_bench
